// ---- pkg/smsr_pkg.sv ----
// Package: register map, field positions, reset values and state encodings
package smsr_pkg;

   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] SMSR_IDX_STAT_LO  = 8'h04;
   localparam logic [7:0] SMSR_IDX_STAT_HI  = 8'h05;
   localparam logic [7:0] SMSR_IDX_CTRL_SET = 8'h08;
   localparam logic [7:0] SMSR_IDX_CTRL_CLR = 8'h09;
   localparam logic [7:0] SMSR_IDX_IRQ_STAT = 8'h10;
   localparam logic [7:0] SMSR_IDX_IRQ_MASK = 8'h11;

   // ==========================================================
   // Runtime control bit positions
   localparam int SMSR_CTRL_LEAVE_OFF = 0;
   localparam int SMSR_CTRL_IRQ_REL   = 1;
   localparam int SMSR_CTRL_GO_OFF    = 2;
   localparam int SMSR_CTRL_FORCE_PRM = 3;
   localparam int SMSR_CTRL_SWAP_EN   = 4;
   localparam int SMSR_CTRL_RELOAD    = 5;
   localparam int SMSR_CTRL_W         = 6;

   // ==========================================================
   // Interrupt status bit positions
   localparam int SMSR_IRQ_ONLINE  = 0;
   localparam int SMSR_IRQ_OFFLINE = 1;
   localparam int SMSR_IRQ_VIOL    = 2;
   localparam int SMSR_IRQ_PRM     = 3;
   localparam int SMSR_IRQ_W       = 4;

   // ==========================================================
   // Reset values
   localparam logic [5:0]  SMSR_CTRL_RST  = 6'h00;
   localparam logic [3:0]  SMSR_MASK_RST  = 4'h0;
   localparam logic [31:0] SMSR_RDATA_RST = 32'h0000_0000;

   // ==========================================================
   // Buffer memory address folding
   localparam int          SMSR_BUF_AW    = 11;
   localparam logic [10:0] SMSR_BUF_LIMIT = 11'h600;
   localparam logic [10:0] SMSR_BUF_FOLD  = 11'h400;

   // ==========================================================
   // Device and protocol states
   typedef enum logic {
      SMSR_OFFLINE      = 1'b0,
      SMSR_PASSIVE_IDLE = 1'b1
   } smsr_dev_t;

   typedef enum logic [1:0] {
      SMSR_PRM_WAIT       = 2'b00,
      SMSR_CFG_WAIT       = 2'b01,
      SMSR_EXCHANGE_PHASE = 2'b10
   } smsr_proto_t;

   localparam logic [1:0] SMSR_PROTO_BAD = 2'b11;

endpackage

// ---- rtl/smsr_regs.sv ----
// Runtime control and status registers of the fieldbus slave, APB slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - Control byte has a set address and a clear address, bits independent.
// - Only bit positions written as one change; zeros leave bits alone.
// - Leave-offline bit moves to passive idle, starts timers, drops go-offline.
// - Release bit pulses interrupt release and then clears itself.
// - Go-offline waits for the current request, goes offline, clears itself.
// - Force bit puts the protocol state into parameter wait, then clears.
// - Swap-enable bit gates the buffer swap on configuration accept.
// - Reload bit reloads the user guard timer, then clears itself.
// - Status register is read-only, low byte and high byte apart.
// - Status bit 0 is zero offline and one in passive idle.
// - Buffer addresses at or past the limit fold down and flag a violation.
// - Protocol field: 00 parameter wait, 01 config wait, 10 exchange.
// - Diagnostic flag reads one until the master has fetched diagnostics.
module smsr_regs
   import smsr_pkg::*;
#(
   parameter int       ADDR_W  = 12,
   parameter bit [3:0] RELEASE = 4'h1   // Arbitrary release code
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata_q,
   output logic                   pready_q,
   output logic                   pslverr_q,
   // Protocol engine side
   input  wire logic              req_busy,
   input  wire logic              proto_load,
   input  wire logic [1:0]        proto_next,
   input  wire logic              cfg_accept,
   input  wire logic              link_ind_buffered,
   input  wire logic              diag_pending,
   input  wire logic [1:0]        guard_fsm_state,
   input  wire logic [3:0]        baud_rate,
   // Buffer memory address path
   input  wire logic              buf_req,
   input  wire logic [10:0]       buf_addr,
   output logic                   buf_req_q,
   output logic      [10:0]       buf_addr_q,
   // Commands and state
   output logic                   dev_online_q,
   output logic      [1:0]        protocol_state_q,
   output logic                   timers_start_q,
   output logic                   irq_release_q,
   output logic                   reload_user_guard_q,
   output logic                   cfg_swap_q,
   // Interrupt
   output logic                   irq_q
);

   // ==========================================================
   // Declarations
   smsr_dev_t             dev_q;
   smsr_dev_t             dev_d;
   smsr_proto_t           proto_q;
   logic [5:0]            ctrl_q;
   logic [5:0]            ctrl_d;
   logic [5:0]            auto_clr;
   logic [3:0]            mask_q;
   logic [3:0]            irq_flags;
   logic [3:0]            irq_set;
   logic [3:0]            irq_clr;
   logic                  viol_flag;
   logic                  viol_set;
   logic                  viol_clr;
   logic                  acc;
   logic                  ld;
   logic                  done;
   logic                  mapped;
   logic [7:0]            idx;
   logic                  wr;
   logic                  rd;
   logic                  wr_set;
   logic                  wr_clr;
   logic [31:0]           rd_mux;
   logic [7:0]            stat_lo;
   logic [7:0]            stat_hi;
   logic                  do_start;
   logic                  do_eoi;
   logic                  do_off;
   logic                  do_leave;
   logic                  do_reload;
   logic                  buf_over;
   logic [10:0]           buf_fold;

   // ==========================================================
   // APB decode
   assign acc    = psel & penable;
   assign ld     = acc & ~pready_q;
   assign done   = acc & pready_q;
   assign idx    = paddr[9:2];
   assign mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0)
                   && (idx == SMSR_IDX_STAT_LO || idx == SMSR_IDX_STAT_HI
                    || idx == SMSR_IDX_CTRL_SET || idx == SMSR_IDX_CTRL_CLR
                    || idx == SMSR_IDX_IRQ_STAT || idx == SMSR_IDX_IRQ_MASK);
   assign wr     = done & pwrite & mapped;
   assign rd     = done & ~pwrite & mapped;
   assign wr_set = wr & (idx == SMSR_IDX_CTRL_SET);
   assign wr_clr = wr & (idx == SMSR_IDX_CTRL_CLR);

   // Status bytes, never written
   assign stat_lo = {guard_fsm_state, proto_q, viol_flag, diag_pending,
                     link_ind_buffered, dev_q == SMSR_PASSIVE_IDLE};
   assign stat_hi = {RELEASE, baud_rate};

   // Read multiplexer, upper bits zero
   always_comb begin
      rd_mux = SMSR_RDATA_RST;
      case (idx)
         SMSR_IDX_STAT_LO:  rd_mux[7:0] = stat_lo;
         SMSR_IDX_STAT_HI:  rd_mux[7:0] = stat_hi;
         SMSR_IDX_CTRL_SET: rd_mux[5:0] = ctrl_q;
         SMSR_IDX_CTRL_CLR: rd_mux[5:0] = ctrl_q;
         SMSR_IDX_IRQ_STAT: rd_mux[3:0] = irq_flags;
         SMSR_IDX_IRQ_MASK: rd_mux[3:0] = mask_q;
         default:           rd_mux      = SMSR_RDATA_RST;
      endcase
   end

   // One wait state so read data comes from a flop
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= SMSR_RDATA_RST;
      end else begin
         pready_q  <= ld;
         pslverr_q <= ld & ~mapped;
         if (ld) begin
            prdata_q <= mapped ? rd_mux : SMSR_RDATA_RST;
         end
      end
   end

   // ==========================================================
   // Command actions from pending control bits
   assign do_start  = ctrl_q[SMSR_CTRL_LEAVE_OFF];
   assign do_eoi    = ctrl_q[SMSR_CTRL_IRQ_REL];
   assign do_off    = ctrl_q[SMSR_CTRL_GO_OFF] & ~do_start & ~req_busy;
   assign do_leave  = ctrl_q[SMSR_CTRL_FORCE_PRM];
   assign do_reload = ctrl_q[SMSR_CTRL_RELOAD];

   // Self-clearing bits, swap enable kept
   assign auto_clr = {do_reload, 1'b0, do_leave, do_off | do_start, do_eoi, do_start};

   // Control next value; host set beats auto clear
   always_comb begin
      ctrl_d = ctrl_q & ~auto_clr;
      if (wr_set) begin
         ctrl_d = ctrl_d | pwdata[5:0];
      end
      if (wr_clr) begin
         ctrl_d = ctrl_d & ~pwdata[5:0];
      end
   end

   // Control register
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= SMSR_CTRL_RST;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Device state: offline or passive idle
   always_comb begin
      dev_d = dev_q;
      case (dev_q)
         SMSR_OFFLINE: begin
            if (do_start) begin
               dev_d = SMSR_PASSIVE_IDLE;
            end
         end
         SMSR_PASSIVE_IDLE: begin
            if (do_off) begin
               dev_d = SMSR_OFFLINE;
            end
         end
         default: dev_d = SMSR_OFFLINE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dev_q        <= SMSR_OFFLINE;
         dev_online_q <= 1'b0;
      end else begin
         dev_q        <= dev_d;
         dev_online_q <= dev_d == SMSR_PASSIVE_IDLE;
      end
   end

   // Protocol state; force to parameter wait wins, code 11 refused
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         proto_q          <= SMSR_PRM_WAIT;
         protocol_state_q <= SMSR_PRM_WAIT;
      end else begin
         if (do_leave || do_off) begin
            proto_q          <= SMSR_PRM_WAIT;
            protocol_state_q <= SMSR_PRM_WAIT;
         end else if (proto_load && proto_next != SMSR_PROTO_BAD) begin
            proto_q          <= smsr_proto_t'(proto_next);
            protocol_state_q <= proto_next;
         end
      end
   end

   // Command pulses to timers, interrupt controller and buffer swap
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         timers_start_q      <= 1'b0;
         irq_release_q       <= 1'b0;
         reload_user_guard_q <= 1'b0;
         cfg_swap_q          <= 1'b0;
      end else begin
         timers_start_q      <= do_start;
         irq_release_q       <= do_eoi;
         reload_user_guard_q <= do_reload;
         cfg_swap_q          <= cfg_accept & ctrl_q[SMSR_CTRL_SWAP_EN];
      end
   end

   // ==========================================================
   // Buffer address folding
   assign buf_over = buf_addr >= SMSR_BUF_LIMIT;
   assign buf_fold = buf_over ? buf_addr - SMSR_BUF_FOLD : buf_addr;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         buf_req_q  <= 1'b0;
         buf_addr_q <= 11'h000;
      end else begin
         buf_req_q <= buf_req;
         if (buf_req) begin
            buf_addr_q <= buf_fold;
         end
      end
   end

   // Violation flag, cleared by reading the low status byte
   assign viol_set = buf_req & buf_over;
   assign viol_clr = rd & (idx == SMSR_IDX_STAT_LO);

   smsr_sticky #(
      .W (1)
   ) u_viol (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .set     (viol_set),
      .clr     (viol_clr),
      .flags_q (viol_flag)
   );

   // ==========================================================
   // Interrupt status, mask and output
   assign irq_set = {do_leave, viol_set,
                     do_off & (dev_q == SMSR_PASSIVE_IDLE),
                     do_start & (dev_q == SMSR_OFFLINE)};
   assign irq_clr = (rd && idx == SMSR_IDX_IRQ_STAT) ? 4'hF : 4'h0;

   smsr_sticky #(
      .W (SMSR_IRQ_W)
   ) u_irq (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .set     (irq_set),
      .clr     (irq_clr),
      .flags_q (irq_flags)
   );

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mask_q <= SMSR_MASK_RST;
         irq_q  <= 1'b0;
      end else begin
         if (wr && idx == SMSR_IDX_IRQ_MASK) begin
            mask_q <= pwdata[3:0];
         end
         irq_q <= |(irq_flags & mask_q);
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   a_set_write_bit: assert property (
      wr_set && pwdata[SMSR_CTRL_SWAP_EN] |=> ctrl_q[SMSR_CTRL_SWAP_EN])
      else $error("Set address did not set swap enable");

   a_zero_keeps_bit: assert property (
      (wr_set || wr_clr) && !pwdata[SMSR_CTRL_SWAP_EN]
      |=> $stable(ctrl_q[SMSR_CTRL_SWAP_EN]))
      else $error("Zero write changed a control bit");

   a_leave_offline: assert property (
      do_start && !(wr_set && pwdata[SMSR_CTRL_GO_OFF])
      |=> dev_online_q && timers_start_q && !ctrl_q[SMSR_CTRL_GO_OFF])
      else $error("Leave offline did not take effect");

   a_irq_release: assert property (
      do_eoi && !wr_set |=> irq_release_q && !ctrl_q[SMSR_CTRL_IRQ_REL])
      else $error("Interrupt release not pulsed and cleared");

   a_go_offline: assert property (
      ctrl_q[SMSR_CTRL_GO_OFF] && req_busy && !do_start && !wr_clr
      |=> ctrl_q[SMSR_CTRL_GO_OFF] && $stable(dev_online_q))
      else $error("Go offline acted during a busy request");

   a_force_prm: assert property (
      do_leave |=> proto_q == SMSR_PRM_WAIT)
      else $error("Force did not reach parameter wait");

   a_swap_gate: assert property (
      cfg_accept |=> cfg_swap_q == $past(ctrl_q[SMSR_CTRL_SWAP_EN]))
      else $error("Buffer swap not gated by enable");

   a_reload_guard: assert property (
      do_reload && !wr_set |=> reload_user_guard_q ##1 !reload_user_guard_q)
      else $error("Guard reload not a single pulse");

   a_stat_bit0: assert property (
      ld && idx == SMSR_IDX_STAT_LO && mapped
      |=> prdata_q[0] == $past(dev_online_q))
      else $error("Status bit 0 does not match state");

   a_fold_addr: assert property (
      buf_req && buf_over |=> buf_addr_q == $past(buf_addr) - SMSR_BUF_FOLD
      && viol_flag)
      else $error("Buffer address not folded");

   a_no_code3: assert property (
      proto_q != SMSR_PROTO_BAD)
      else $error("Protocol state code 11 seen");

   a_diag_flag: assert property (
      ld && idx == SMSR_IDX_STAT_LO && mapped
      |=> prdata_q[2] == $past(diag_pending))
      else $error("Diagnostic flag wrong");

   a_unused_bits: assert property (
      ld && (idx == SMSR_IDX_CTRL_SET) |=> prdata_q[7:6] == 2'h0)
      else $error("Unused control bits read nonzero");

   c_go_online:  cover property (do_start && dev_q == SMSR_OFFLINE);
   c_go_offline: cover property (do_off && dev_q == SMSR_PASSIVE_IDLE);
   c_swap:       cover property (cfg_swap_q);
   c_fold:       cover property (viol_set ##1 irq_q);

endmodule

// ---- rtl/smsr_sticky.sv ----
// Sticky flag vector: hardware set wins over a clear in the same cycle
`timescale 1ns/1ps
module smsr_sticky #(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   // Set and clear strobes
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   // Flags
   output logic      [W-1:0] flags_q
);

   // ==========================================================
   // Flag storage
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~clr) | set;
      end
   end

endmodule

// ---- tb/smsr_host.sv ----
// Host processor model: APB master that drives the register bus
`timescale 1ns/1ps
module smsr_host (
   // Clock
   input  wire logic        clk_sys,
   // APB request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   // APB answer
   input  wire logic [31:0] prdata_q,
   input  wire logic        pready_q,
   input  wire logic        pslverr_q
);
   // ==========================================================
   // Idle bus at time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
   end

   // One transfer, held until pready is seen at a rising edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      int n;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready_q !== 1'b1);
      r = prdata_q;
      e = pslverr_q;
      // Release; stale address and data are scrambled, not held
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
endmodule

// ---- tb/smsr_regs_test.sv ----
// Self-checking testbench of the runtime control and status registers
`timescale 1ns/1ps
module smsr_regs_test;
   import smsr_pkg::*;
   // ==========================================================
   // Signals
   logic clk_sys, nrst, psel, penable, pwrite, pready_q, pslverr_q, irq_q, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata_q, v;
   logic req_busy, proto_load, cfg_accept, link_ind_buffered, diag_pending, buf_req;
   logic [1:0] proto_next, guard_fsm_state, protocol_state_q;
   logic [3:0] baud_rate;
   logic [10:0] buf_addr, buf_addr_q;
   logic dev_online_q, timers_start_q, irq_release_q, reload_user_guard_q, cfg_swap_q;
   int error_cnt, n_checks, n_start, n_rel, n_reload, n_swap;

   smsr_host host_u (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
      .pslverr_q(pslverr_q));

   smsr_regs dut_u (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
      .pready_q(pready_q), .pslverr_q(pslverr_q), .req_busy(req_busy),
      .proto_load(proto_load), .proto_next(proto_next), .cfg_accept(cfg_accept),
      .link_ind_buffered(link_ind_buffered), .diag_pending(diag_pending),
      .guard_fsm_state(guard_fsm_state), .baud_rate(baud_rate), .buf_req(buf_req),
      .buf_addr(buf_addr), .buf_req_q(), .buf_addr_q(buf_addr_q),
      .dev_online_q(dev_online_q), .protocol_state_q(protocol_state_q),
      .timers_start_q(timers_start_q), .irq_release_q(irq_release_q),
      .reload_user_guard_q(reload_user_guard_q), .cfg_swap_q(cfg_swap_q), .irq_q(irq_q));

   // ==========================================================
   // Clock, 4 ns period
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // Command pulse counters
   always @(posedge clk_sys) begin
      if (timers_start_q === 1'b1) n_start++;
      if (irq_release_q === 1'b1) n_rel++;
      if (reload_user_guard_q === 1'b1) n_reload++;
      if (cfg_swap_q === 1'b1) n_swap++;
   end

   // ==========================================================
   // Compare, bus helpers and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, v, err);
   endtask

   task automatic rd(input logic [11:0] a);
      host_u.xfer(1'b0, a, 32'h0000_0000, v, err);
   endtask

   task automatic stop_test;
      $display("Checks %0d, errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      stop_test;
   end

   // ==========================================================
   // Main sequence
   initial begin
      nrst = 1'b0; req_busy = 1'b0; proto_load = 1'b0; proto_next = 2'b00;
      cfg_accept = 1'b0; link_ind_buffered = 1'b0; diag_pending = 1'b0;
      guard_fsm_state = 2'b00; baud_rate = 4'hA; buf_req = 1'b0; buf_addr = 11'h000;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(12'h020); check(v, 32'h0000_0000);
      rd(12'h010); check(v, 32'h0000_0000);
      rd(12'h014); check(v, 32'h0000_001A);
      wr(12'h010, 32'h0000_00FF); rd(12'h010); check(v, 32'h0000_0000);
      rd(12'h030); check({31'h0, err}, 32'h1);
      // Set and clear addresses, zeros and unused bits
      wr(12'h020, 32'h0000_00D0); rd(12'h020); check(v, 32'h0000_0010);
      wr(12'h024, 32'h0000_00C0); rd(12'h024); check(v, 32'h0000_0010);
      @(posedge clk_sys) cfg_accept <= 1'b1;
      @(posedge clk_sys) cfg_accept <= 1'b0;
      repeat (2) @(posedge clk_sys); check(n_swap, 1);
      wr(12'h024, 32'h0000_0010); rd(12'h020); check(v, 32'h0000_0000);
      @(posedge clk_sys) cfg_accept <= 1'b1;
      @(posedge clk_sys) cfg_accept <= 1'b0;
      repeat (2) @(posedge clk_sys); check(n_swap, 1);
      // Leave offline with interrupt unmasked
      wr(12'h044, 32'h0000_0003); wr(12'h020, 32'h0000_0001);
      rd(12'h010); check(v, 32'h0000_0001);
      check(n_start, 1);
      check({31'h0, irq_q}, 32'h1);
      rd(12'h040); check(v & 32'h1, 32'h1);
      repeat (3) @(posedge clk_sys); check({31'h0, irq_q}, 32'h0);
      // Go offline waits for the request; leave offline drops it
      req_busy <= 1'b1;
      wr(12'h020, 32'h0000_0004); rd(12'h020); check(v, 32'h0000_0004);
      check({31'h0, dev_online_q}, 32'h1);
      wr(12'h020, 32'h0000_0001); rd(12'h020); check(v, 32'h0000_0000);
      req_busy <= 1'b0;
      repeat (4) @(posedge clk_sys); check({31'h0, dev_online_q}, 32'h1);
      wr(12'h020, 32'h0000_0004);
      repeat (3) @(posedge clk_sys); check({31'h0, dev_online_q}, 32'h0);
      rd(12'h020); check(v, 32'h0000_0000);
      rd(12'h040); check(v & 32'h2, 32'h2);
      // Release and reload pulses, both self-clearing
      wr(12'h020, 32'h0000_0022);
      repeat (3) @(posedge clk_sys); check(n_rel, 1);
      check(n_reload, 1);
      rd(12'h020); check(v, 32'h0000_0000);
      // Protocol field and forced parameter wait
      @(posedge clk_sys) begin proto_load <= 1'b1; proto_next <= 2'b10; end
      @(posedge clk_sys) proto_load <= 1'b0;
      rd(12'h010); check(v, 32'h0000_0020);
      @(posedge clk_sys) begin proto_load <= 1'b1; proto_next <= 2'b11; end
      @(posedge clk_sys) proto_load <= 1'b0;
      rd(12'h010); check(v, 32'h0000_0020);
      wr(12'h020, 32'h0000_0008); rd(12'h010); check(v, 32'h0000_0000);
      // Buffer address folding at the limit
      @(posedge clk_sys) begin buf_req <= 1'b1; buf_addr <= 11'h5FF; end
      @(posedge clk_sys) buf_req <= 1'b0;
      @(posedge clk_sys) check(buf_addr_q, 32'h0000_05FF);
      rd(12'h010); check(v, 32'h0000_0000);
      @(posedge clk_sys) begin buf_req <= 1'b1; buf_addr <= 11'h600; end
      @(posedge clk_sys) buf_req <= 1'b0;
      @(posedge clk_sys) check(buf_addr_q, 32'h0000_0200);
      rd(12'h010); check(v, 32'h0000_0008);
      rd(12'h010); check(v, 32'h0000_0000);
      // Level inputs mirrored in the status byte
      diag_pending <= 1'b1; link_ind_buffered <= 1'b1; guard_fsm_state <= 2'b11;
      rd(12'h010); check(v, 32'h0000_00C6);
      stop_test;
   end
endmodule
